//--- burst_sram_array_model.sv
/*
 burst_sram_array_model: behavioural storage behind the port control.
 assumes lane enables and write data arrive registered on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_sram_array_model
    import burst_sram_pkg::*;
(
    input wire logic core_clk,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [burst_sram_pkg::LANES-1:0] mem_lane_we,
    input wire logic [burst_sram_pkg::DATA_W-1:0] mem_wdata,
    output logic [burst_sram_pkg::DATA_W-1:0] read_data
);
    logic [DATA_W-1:0] mem [16];
    // unwritten words hold a per-address pattern
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {9{i[3:0]}};
        end
    end
    always_ff @(posedge core_clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (mem_lane_we[l]) begin
                mem[mem_addr[3:0]][l*LANE_W +: LANE_W] <=
                    mem_wdata[l*LANE_W +: LANE_W];
            end
        end
    end
    assign read_data = mem[mem_addr[3:0]];
endmodule
`default_nettype wire

//--- burst_sram_pkg.sv
/*
 package of constants for the burst sram port control block.
 assumes nothing of its surroundings.
*/
package burst_sram_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0;
    typedef enum logic [1:0] {
        ST_DESEL = 2'h0,
        ST_FIRST = 2'h1,
        ST_ACTIVE = 2'h3
    } port_state_t;
endpackage

//--- burst_sram_port_control.sv
/*
 burst_sram_port_control: synchronous port control of a pipelined
 burst sram: address capture, burst counter, chip select, byte writes,
 data pin direction.
 assumes a controller on the same core_clk drives the port; the output
 enable and order strap come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_control
    import burst_sram_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] addr,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic byte_write_gate_n,
    input wire logic [burst_sram_pkg::LANES-1:0] byte_lane_select_n,
    input wire logic all_lanes_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order,
    input wire logic [burst_sram_pkg::DATA_W-1:0] dq_in,
    input wire logic [burst_sram_pkg::DATA_W-1:0] read_data,
    output logic [burst_sram_pkg::DATA_W-1:0] dq_out,
    output logic [burst_sram_pkg::DATA_W-1:0] dq_oe,
    output logic [burst_sram_pkg::ADDR_W-1:0] mem_addr,
    output logic [burst_sram_pkg::LANES-1:0] mem_lane_we,
    output logic [burst_sram_pkg::DATA_W-1:0] mem_wdata,
    output logic selected
);
    import burst_sram_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers for output enable and order strap
    logic oe_meta;
    logic oe_sync;
    logic mode_meta;
    logic mode_sync;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            oe_meta <= 1'b1;
            oe_sync <= 1'b1;
            mode_meta <= 1'b1;
            mode_sync <= 1'b1;
        end else begin
            oe_meta <= output_enable_n;
            oe_sync <= oe_meta;
            mode_meta <= burst_order;
            mode_sync <= mode_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strobe and chip select decode
    wire cs_active = !chip_sel_primary_n && chip_sel_second
                     && !chip_sel_third_n;
    // processor strobe counts only with primary enable low
    wire proc_req = !processor_addr_strobe_n
                    && !chip_sel_primary_n;
    // controller strobe used only when processor strobe is idle
    wire ctrl_req = processor_addr_strobe_n
                    && !controller_addr_strobe_n;
    wire new_addr = proc_req || ctrl_req;
    wire capture = new_addr && cs_active;
    wire deselect = new_addr && !cs_active;
    // processor strobe cycles start as reads; writes come later
    wire any_write_in = !all_lanes_write_n
                        || (!byte_write_gate_n && !(&byte_lane_select_n));
    wire proc_write = !proc_req && any_write_in;

    logic [ADDR_W-1:0] base_addr;
    logic [BURST_W-1:0] count;
    port_state_t state;
    port_state_t next_state;
    logic [BURST_W-1:0] low_addr;
    logic [BURST_W-1:0] next_count;

    burst_step u_step (
        .start(base_addr[BURST_W-1:0]),
        .count(count),
        .interleaved(mode_sync),
        .low_addr(low_addr),
        .next_count(next_count)
    );

    // low bits of the beat that a step edge moves to
    logic [BURST_W-1:0] low_next;

    burst_step u_step_next (
        .start(base_addr[BURST_W-1:0]),
        .count(next_count),
        .interleaved(mode_sync),
        .low_addr(low_next),
        .next_count()
    );

    wire stepping = !burst_step_n && !new_addr && (state != ST_DESEL);

    always_comb begin
        next_state = state;
        case (state)
            ST_DESEL: begin
                if (capture) next_state = ST_FIRST;
            end
            ST_FIRST, ST_ACTIVE: begin
                if (deselect) next_state = ST_DESEL;
                else if (capture) next_state = ST_FIRST;
                else next_state = ST_ACTIVE;
            end
            default: next_state = ST_DESEL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // address register and burst counter
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            base_addr <= ADDR_RST;
            count <= BURST_RST;
            state <= ST_DESEL;
        end else begin
            state <= next_state;
            if (capture) begin
                base_addr <= addr;
                count <= BURST_RST;
            end else if (stepping) begin
                count <= next_count;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write lane decode and write data capture
    wire in_cycle = capture || (state != ST_DESEL && !deselect);
    wire [LANES-1:0] byte_we = byte_write_gate_n ? LANES_NONE
                               : ~byte_lane_select_n;
    wire [LANES-1:0] next_we = !in_cycle ? LANES_NONE
                               : (!all_lanes_write_n ? LANES_ALL
                               : byte_we);
    wire [LANES-1:0] lane_we = (capture && !proc_req) || !capture
                               ? next_we : LANES_NONE;
    logic write_cycle;
    logic first_read;
    // direction is decided from this edge's decode so it lands on time
    wire next_write = (|lane_we) || (proc_write && in_cycle);
    wire next_first = capture && (state == ST_DESEL);
    wire next_selected = (next_state != ST_DESEL);
    wire [BURST_W-1:0] beat_low = stepping ? low_next : low_addr;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mem_lane_we <= LANES_NONE;
            mem_wdata <= DATA_RST;
            mem_addr <= ADDR_RST;
            write_cycle <= 1'b0;
            first_read <= 1'b0;
            selected <= 1'b0;
        end else begin
            mem_lane_we <= lane_we;
            mem_wdata <= dq_in;
            mem_addr <= capture ? addr
                        : {base_addr[ADDR_W-1:BURST_W], beat_low};
            write_cycle <= next_write;
            first_read <= next_first;
            selected <= next_selected;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data pin direction
    wire drive = !oe_sync && next_selected && !next_first
                 && !next_write;

    genvar i;
    generate
        for (i = 0; i < DATA_W; i = i + 1) begin : g_dq
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    dq_oe[i] <= 1'b0;
                    dq_out[i] <= 1'b0;
                end else begin
                    dq_oe[i] <= drive;
                    dq_out[i] <= read_data[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // checks
    proc_ignored_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (chip_sel_primary_n && controller_addr_strobe_n) |=> $stable(base_addr))
        else $error("processor strobe captured with primary enable high");
    capture_addr_a: assert property (@(posedge core_clk) disable iff (!rstn)
        capture |=> (base_addr == $past(addr) && count == BURST_RST))
        else $error("address or counter not loaded on capture");
    counter_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
        capture |=> mem_addr[BURST_W-1:0] == $past(addr[BURST_W-1:0]))
        else $error("low address bits not loaded");
    burst_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stepping |=> count == $past(count) + BURST_ONE)
        else $error("burst counter did not step");
    hold_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (burst_step_n && !capture) |=> $stable(count))
        else $error("burst counter moved without step");
    global_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!all_lanes_write_n && in_cycle && !capture) |=> mem_lane_we == LANES_ALL)
        else $error("global write missed lanes");
    byte_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (all_lanes_write_n && byte_write_gate_n) |=> mem_lane_we == LANES_NONE)
        else $error("lane written without gate");
    first_mask_a: assert property (@(posedge core_clk) disable iff (!rstn)
        first_read |-> !dq_oe[0])
        else $error("output driven on first read clock");
    desel_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !selected |-> !dq_oe[0])
        else $error("output driven while deselected");
    wrap_four_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (count == 2'h3 && stepping) |=> count == BURST_RST)
        else $error("burst counter did not wrap");
endmodule
`default_nettype wire

//--- burst_sram_port_control_tb.sv
/*
 burst_sram_port_control_tb: directed scenarios for the port control.
 assumes burst_sram_array_model answers on the array side.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_control_tb;
import burst_sram_pkg::*;
logic core_clk = 1'h0, rstn = 1'h0, burst_order = 1'h0;
logic processor_addr_strobe_n = 1'h1, controller_addr_strobe_n = 1'h1;
logic burst_step_n = 1'h1, byte_write_gate_n = 1'h1;
logic all_lanes_write_n = 1'h1, chip_sel_primary_n = 1'h0;
logic chip_sel_second = 1'h1, chip_sel_third_n = 1'h0;
logic output_enable_n = 1'h0, selected;
logic [ADDR_W-1:0] addr = 18'h0, mem_addr;
logic [LANES-1:0] byte_lane_select_n = 4'hF, mem_lane_we;
logic [DATA_W-1:0] dq_in = 36'h987654321, read_data, dq_out, dq_oe;
logic [DATA_W-1:0] mem_wdata;
int error_cnt = 0, total_checks = 0;
burst_sram_port_control u_burst_sram_port_control (
    .core_clk, .rstn, .addr, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_step_n, .chip_sel_primary_n,
    .chip_sel_second, .chip_sel_third_n, .byte_write_gate_n,
    .byte_lane_select_n, .all_lanes_write_n, .output_enable_n,
    .burst_order, .dq_in, .read_data, .dq_out, .dq_oe, .mem_addr,
    .mem_lane_we, .mem_wdata, .selected);
burst_sram_array_model u_burst_sram_array_model (
    .core_clk, .mem_addr, .mem_lane_we, .mem_wdata, .read_data);
////////////////////////////////////////////////////////////////////////
task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
        error_cnt++;
        $display("BAD %s exp %h seen %h", what, exp, seen);
    end
endtask
task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask
task automatic strobe(input logic proc, input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    processor_addr_strobe_n <= ~proc;
    controller_addr_strobe_n <= proc;
    addr <= a;
endtask
// release strobes and write enables; a step also drops chip_sel_second to show it unused
task automatic idle_next(input logic stp);
    @(posedge core_clk);
    processor_addr_strobe_n <= 1'h1;
    controller_addr_strobe_n <= 1'h1;
    burst_step_n <= stp;
    chip_sel_second <= stp;
    chip_sel_primary_n <= 1'h0;
    all_lanes_write_n <= 1'h1;
    byte_write_gate_n <= 1'h1;
    #1;
endtask
////////////////////////////////////////////////////////////////////////
task automatic s_writes;
    strobe(1'h0, 18'h11);
    byte_write_gate_n <= 1'h0;
    byte_lane_select_n <= 4'hA;
    idle_next(1'h1);
    chk("lane_we", mem_lane_we, 4'h5);
    strobe(1'h0, 18'h12);
    byte_lane_select_n <= 4'h0;
    idle_next(1'h1);
    chk("lane_we", mem_lane_we, LANES_NONE);
    strobe(1'h0, 18'h10);
    all_lanes_write_n <= 1'h0;
    idle_next(1'h1);
    chk("addr", mem_addr, 18'h10);
    chk("lane_we", mem_lane_we, LANES_ALL);
    chk("wdata", mem_wdata, 36'h987654321);
    chk("selected", selected, 1'h1);
endtask
task automatic s_strobes;
    strobe(1'h1, 18'h13);
    controller_addr_strobe_n <= 1'h0;
    all_lanes_write_n <= 1'h0;
    idle_next(1'h1);
    chk("addr", mem_addr, 18'h13);
    chk("lane_we", mem_lane_we, LANES_NONE);
    strobe(1'h1, 18'h20);
    chip_sel_primary_n <= 1'h1;
    idle_next(1'h1);
    chk("addr", mem_addr, 18'h13);
endtask
task automatic s_burst(input logic mode);
    @(posedge core_clk);
    burst_order <= mode;
    repeat (3) @(posedge core_clk);
    strobe(1'h0, 18'hA5B);
    idle_next(1'h0);
    idle_next(1'h1);
    chk("addr", mem_addr, mode ? 18'hA5A : 18'hA58);
    chk("selected", selected, 1'h1);
endtask
task automatic s_read;
    strobe(1'h0, 18'h30);
    chip_sel_second <= 1'h0;
    idle_next(1'h1);
    chk("selected", selected, 1'h0);
    chk("oe", dq_oe, 36'h0);
    strobe(1'h0, 18'h10);
    idle_next(1'h1);
    chk("oe", dq_oe, 36'h0);
    idle_next(1'h1);
    chk("oe", dq_oe, 36'hFFFFFFFFF);
    chk("dq_out", dq_out, 36'h987654321);
    @(posedge core_clk);
    all_lanes_write_n <= 1'h0;
    idle_next(1'h1);
    chk("oe", dq_oe, 36'h0);
    output_enable_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("oe", dq_oe, 36'h0);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    forever #2 core_clk = ~core_clk;
end
initial begin
    repeat (1000) @(posedge core_clk);
    error_cnt++;
    print_verdict;
end
initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    #1;
    chk("selected", selected, 1'h0);
    s_writes;
    s_strobes;
    s_burst(1'h0);
    s_burst(1'h1);
    s_read;
    print_verdict;
end
endmodule
`default_nettype wire

//--- burst_step.sv
/*
 burst_step: low address bits of the current beat and the next count of a four-beat burst.
 assumes the order strap is static while bursts run.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_step
    import burst_sram_pkg::*;
(
    input wire logic [BURST_W-1:0] start,
    input wire logic [BURST_W-1:0] count,
    input wire logic interleaved,
    output logic [BURST_W-1:0] low_addr,
    output logic [BURST_W-1:0] next_count
);
    // count wraps modulo four
    assign next_count = count + BURST_ONE;
    // interleaved order xors the start, linear order adds to it
    assign low_addr = interleaved ? (start ^ count)
                                  : (start + count);
endmodule
`default_nettype wire
